// *** design/fcp_top.sv ***
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Non-DMA flag set uses programmed transfers
// - Non-DMA raises interrupt per data byte
// - DMA mode uses request and acknowledge
// - Perpendicular low bits writable only when permitted
// - Sense command reports current cylinder
// - Polling disable flag stops drive polling
// - Precomp start track spans full byte
// - Sector number gives first sector
// - Relative seek adds offset to cylinder
// - Sector count bounds format and counted verify
// - Bypass set skips deleted sectors on read
// - Read-deleted with bypass touches deleted only
// - Bypass clear transfers all sectors
// - Step interval 0.5 to 8 ms at rate code 0; doubles per higher rate code
// - Four result bytes held for host
// - Pre-erase flag delays write enable
// - Size code gives 128 shifted bytes
// - Multi-track continues onto head one
// - Density bit selects DOUBLE_DENSITY_SELECT or FM
module fcp_top
    import fcp_pkg::*;
(
    input  wire logic        i_ref_clk,     // 250 MHz clock.
    input  wire logic        i_rst_n,       // Synchronous reset, active low.
    input  wire fcp_bus_s    i_bus,         // Avalon-MM request.
    output logic [31:0]      o_readdata,    // Avalon-MM read data.
    output logic             o_waitrequest, // Avalon-MM wait.
    input  wire logic        i_dma_acknowledge, // DMA acknowledge pin, active high.
    input  wire logic        i_deleted_mark,    // Drive reports deleted mark on sector.
    output logic             o_dma_request, // DMA request.
    output logic             o_host_irq,    // Per-byte service request.
    output logic             o_step,        // Step pulse to drive.
    output logic             o_write_enable,// Write enable to drive.
    output logic             o_head_sel,    // Head select.
    output logic             o_poll_active, // One-cycle pulse per polling period.
    output logic             o_mfm          // Double density selected.
);

    // ------------------------------------------------------------------
    // Registers and pin synchronisers
    // ------------------------------------------------------------------
    logic [31:0] mode, next_mode;
    logic [7:0]  sector_start, next_sector_start, sectors_per_track, next_sectors_per_track;
    logic [2:0]  size_code, next_size_code;
    logic [7:0]  relative_cylinder_offset, next_relative_cylinder_offset;
    logic [3:0]  step_interval, next_step_interval, perp_bits, next_perp_bits;
    logic [7:0]  current_cylinder, next_current_cylinder;
    fcp_result_s result, next_result;
    fcp_state_e  state, next_state;
    fcp_cmd_e    cmd, next_cmd;
    logic [7:0]  sector, next_sector, done_cnt, next_done_cnt, data_q, next_data_q;
    logic [14:0] byte_cnt, next_byte_cnt;
    logic [31:0] timer, next_timer, poll_cnt, next_poll_cnt;
    logic        head, next_head, dma_req, next_dma_req, irq, next_irq;
    logic        step_q, next_step_q, we, next_we, ack_pend, next_ack_pend;
    logic        waitreq, next_waitreq, poll, next_poll;
    logic [31:0] rdata, next_rdata;
    logic [1:0]  dma_acknowledge_sync, del_sync;
    logic        dma_acknowledge, delm;

    // Two flip-flops on the acknowledge and deleted-mark pins before any logic reads them.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            dma_acknowledge_sync <= 2'h0;
            del_sync  <= 2'h0;
        end else begin
            dma_acknowledge_sync <= {dma_acknowledge_sync[0], i_dma_acknowledge};
            del_sync  <= {del_sync[0], i_deleted_mark};
        end
    end
    assign dma_acknowledge = dma_acknowledge_sync[1];
    assign delm = del_sync[1];

    // ------------------------------------------------------------------
    // Bus slave and sequencer
    // ------------------------------------------------------------------
    logic        wr, rd, non_dma, bypass, is_rw;
    logic [14:0] sec_bytes;
    logic [31:0] step_cyc;
    assign wr      = i_bus.write & waitreq;
    assign rd      = i_bus.read & waitreq;
    assign non_dma = mode[FCP_B_NON_DMA];
    assign bypass  = mode[FCP_B_BYPASS];
    assign is_rw   = (cmd == FCP_CMD_READ) || (cmd == FCP_CMD_READ_DEL)
                  || (cmd == FCP_CMD_WRITE);
    // Sector size is 128 shifted by the size code.
    assign sec_bytes = 15'h0080 << size_code;
    // Step time in cycles; each higher rate code doubles it.
    assign step_cyc = (32'(step_interval) + 32'h1) * 32'(FCP_STEP_UNIT_CYC)
                      << mode[FCP_B_RATE +: 2];

    // Waitrequest drops for one cycle per access, so every access takes two cycles.
    always_comb begin
        next_mode = mode;
        next_sector_start = sector_start;
        next_sectors_per_track = sectors_per_track;
        next_size_code = size_code;
        next_relative_cylinder_offset = relative_cylinder_offset;
        next_step_interval = step_interval;
        next_perp_bits = perp_bits;
        next_current_cylinder = current_cylinder;
        next_result = result;
        next_state = state;
        next_cmd = cmd;
        next_sector = sector;
        next_done_cnt = done_cnt;
        next_data_q = data_q;
        next_byte_cnt = byte_cnt;
        next_timer = timer;
        next_head = head;
        next_dma_req = dma_req;
        next_irq = irq;
        next_step_q = 1'b0;
        next_we = 1'b0;
        next_ack_pend = ack_pend;
        next_waitreq = 1'b1;
        next_rdata = rdata;
        if ((i_bus.read | i_bus.write) && waitreq) begin
            next_waitreq = 1'b0;
        end
        // Settings persist until software writes them again.
        if (wr) begin
            case (i_bus.address)
                FCP_OFF_MODE: next_mode = i_bus.writedata;
                FCP_OFF_SECTOR: begin
                    next_sector_start = i_bus.writedata[7:0];
                    next_sectors_per_track = i_bus.writedata[15:8];
                    next_size_code = i_bus.writedata[18:16];
                end
                FCP_OFF_SEEK: begin
                    next_relative_cylinder_offset = i_bus.writedata[7:0];
                    next_step_interval = i_bus.writedata[11:8];
                end
                FCP_OFF_PERP: begin
                    if (mode[FCP_B_PERMIT]) begin
                        next_perp_bits = i_bus.writedata[3:0];
                    end
                end
                FCP_OFF_CMD: begin
                    if (state == FCP_IDLE) begin
                        next_cmd = fcp_cmd_e'(i_bus.writedata[2:0]);
                        next_sector = sector_start;
                        next_head = 1'b0;
                        next_done_cnt = 8'h00;
                        next_state = FCP_SECTOR;
                    end
                end
                FCP_OFF_DATA: begin
                    next_data_q = i_bus.writedata[7:0];
                    next_ack_pend = 1'b1;
                end
                default: ;
            endcase
        end
        if (rd) begin
            case (i_bus.address)
                FCP_OFF_MODE:   next_rdata = mode;
                FCP_OFF_SECTOR: next_rdata = {13'h0, size_code, sectors_per_track, sector_start};
                FCP_OFF_SEEK:   next_rdata = {20'h0, step_interval, relative_cylinder_offset};
                FCP_OFF_PERP:   next_rdata = {28'h0, perp_bits};
                FCP_OFF_STATUS: next_rdata = {8'h0, current_cylinder, sector, 3'h0, state};
                FCP_OFF_RESULT: next_rdata = result;
                FCP_OFF_DATA: begin
                    next_rdata = {24'h0, data_q};
                    next_ack_pend = 1'b1;
                end
                default: next_rdata = 32'h0;
            endcase
        end
        case (state)
            // A data access outside a transfer must not pre-acknowledge the next one.
            FCP_IDLE: next_ack_pend = 1'b0;
            FCP_SECTOR: begin
                next_byte_cnt = sec_bytes;
                next_timer = 32'(FCP_PREERASE_CYC);
                if (cmd == FCP_CMD_RSEEK) begin
                    next_timer = step_cyc;
                    next_state = FCP_STEP;
                end else if (cmd == FCP_CMD_SENSE) begin
                    next_result.byte1 = current_cylinder;
                    next_state = FCP_RESULT;
                end else if (is_rw && bypass && (delm != (cmd == FCP_CMD_READ_DEL))) begin
                    // Skip the mismatching sector without transfer.
                    next_sector = sector + 8'h01;
                    next_done_cnt = done_cnt + 8'h01;
                    if (done_cnt + 8'h01 >= sectors_per_track) begin
                        next_state = FCP_RESULT;
                    end
                end else begin
                    next_state = FCP_XFER;
                end
            end
            FCP_XFER: begin
                if (timer != 32'h0) begin
                    next_timer = timer - 32'h1;
                end
                // Pre-erase delays the write enable.
                next_we = (cmd == FCP_CMD_WRITE || cmd == FCP_CMD_FORMAT)
                          && (!mode[FCP_B_PREERASE] || timer == 32'h0);
                if (!dma_req && !irq && !ack_pend) begin
                    if (non_dma) begin
                        next_irq = 1'b1;
                    end else if (!dma_acknowledge) begin
                        // Wait for the old answer to drop, so it cannot ack this one.
                        next_dma_req = 1'b1;
                    end
                end
                if ((dma_req && dma_acknowledge) || (irq && ack_pend)) begin
                    next_dma_req = 1'b0;
                    next_irq = 1'b0;
                    // A data access in this very cycle is kept: the set wins.
                    next_ack_pend = (rd | wr) && (i_bus.address == FCP_OFF_DATA);
                    next_byte_cnt = byte_cnt - 15'h1;
                    if (byte_cnt == 15'h1) begin
                        next_done_cnt = done_cnt + 8'h01;
                        next_sector = sector + 8'h01;
                        next_state = FCP_SECTOR;
                        // Count limit bounds format and counted verify.
                        if (done_cnt + 8'h01 >= sectors_per_track
                            && (cmd != FCP_CMD_VERIFY || mode[FCP_B_VCOUNT])) begin
                            next_state = FCP_RESULT;
                            if (mode[FCP_B_MULTI_TRK] && !head && is_rw) begin
                                // Roll onto head one's first sector.
                                next_head = 1'b1;
                                next_sector = 8'h01;
                                next_done_cnt = 8'h00;
                                next_state = FCP_SECTOR;
                            end
                        end
                    end
                end
            end
            FCP_STEP: begin
                next_timer = timer - 32'h1;
                if (timer == 32'h1) begin
                    next_step_q = 1'b1;
                    // Offset adds to present cylinder.
                    next_current_cylinder = current_cylinder + relative_cylinder_offset;
                    next_state = FCP_RESULT;
                end
            end
            FCP_RESULT: begin
                next_result.byte0 = {3'h0, head, 1'b0, 3'h0};
                next_result.byte2 = sector;
                next_result.byte3 = {1'b0, perp_bits, 3'h0};
                if (cmd != FCP_CMD_SENSE) begin
                    next_result.byte1 = done_cnt;
                end
                next_state = FCP_IDLE;
            end
            default: next_state = FCP_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            mode <= FCP_RST_MODE;
            sector_start <= FCP_RST_SECTOR;
            sectors_per_track <= FCP_RST_SPT;
            size_code <= FCP_RST_SIZE;
            relative_cylinder_offset <= 8'h00;
            step_interval <= FCP_RST_STEP;
            perp_bits <= 4'h0;
            current_cylinder <= 8'h00;
            result <= '0;
            state <= FCP_IDLE;
            cmd <= FCP_CMD_READ;
            sector <= 8'h00;
            done_cnt <= 8'h00;
            data_q <= 8'h00;
            byte_cnt <= 15'h0;
            timer <= 32'h0;
            head <= 1'b0;
            dma_req <= 1'b0;
            irq <= 1'b0;
            step_q <= 1'b0;
            we <= 1'b0;
            ack_pend <= 1'b0;
            waitreq <= 1'b1;
            rdata <= 32'h0;
        end else begin
            mode <= next_mode;
            sector_start <= next_sector_start;
            sectors_per_track <= next_sectors_per_track;
            size_code <= next_size_code;
            relative_cylinder_offset <= next_relative_cylinder_offset;
            step_interval <= next_step_interval;
            perp_bits <= next_perp_bits;
            current_cylinder <= next_current_cylinder;
            result <= next_result;
            state <= next_state;
            cmd <= next_cmd;
            sector <= next_sector;
            done_cnt <= next_done_cnt;
            data_q <= next_data_q;
            byte_cnt <= next_byte_cnt;
            timer <= next_timer;
            head <= next_head;
            dma_req <= next_dma_req;
            irq <= next_irq;
            step_q <= next_step_q;
            we <= next_we;
            ack_pend <= next_ack_pend;
            waitreq <= next_waitreq;
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Drive polling
    // ------------------------------------------------------------------
    // Polling runs only while idle and not disabled.
    always_comb begin
        next_poll_cnt = poll_cnt + 32'h1;
        next_poll = 1'b0;
        if (mode[FCP_B_POLL_DIS] || state != FCP_IDLE) begin
            next_poll_cnt = 32'h0;
        end else if (poll_cnt >= 32'(FCP_POLL_CYC) - 32'h1) begin
            next_poll_cnt = 32'h0;
            next_poll = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            poll_cnt <= 32'h0;
            poll <= 1'b0;
        end else begin
            poll_cnt <= next_poll_cnt;
            poll <= next_poll;
        end
    end

    assign o_readdata     = rdata;
    assign o_waitrequest  = waitreq;
    assign o_dma_request  = dma_req;
    assign o_host_irq     = irq;
    assign o_step         = step_q;
    assign o_write_enable = we;
    assign o_head_sel     = head;
    assign o_poll_active  = poll;
    assign o_mfm          = mode[FCP_B_DDENS];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_perm;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !mode[FCP_B_PERMIT] |=> $stable(perp_bits);
    endproperty
    a_perm: assert property (p_perm) else $error("perp bits changed without permit");

    property p_nodma;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        non_dma |-> !o_dma_request || $past(!non_dma);
    endproperty
    a_nodma: assert property (p_nodma) else $error("dma request in non-dma mode");

    property p_irq;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == FCP_XFER && non_dma && !irq && !ack_pend) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("no per-byte interrupt");

    property p_dma;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (dma_req && dma_acknowledge && state == FCP_XFER) |=> !dma_req;
    endproperty
    a_dma: assert property (p_dma) else $error("dma request not dropped");

    property p_dma_rise;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(dma_req) |-> !$past(dma_acknowledge);
    endproperty
    a_dma_rise: assert property (p_dma_rise) else $error("dma request under stale ack");

    property p_seek;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == FCP_STEP && timer == 32'h1) |=>
            current_cylinder == $past(current_cylinder) + $past(relative_cylinder_offset);
    endproperty
    a_seek: assert property (p_seek) else $error("relative seek wrong");

    property p_poll;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        mode[FCP_B_POLL_DIS] |=> !o_poll_active;
    endproperty
    a_poll: assert property (p_poll) else $error("poll while disabled");

    property p_sense;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == FCP_SECTOR && cmd == FCP_CMD_SENSE) |=> ##1 result.byte1 == current_cylinder;
    endproperty
    a_sense: assert property (p_sense) else $error("sense cylinder missing");

    property p_start;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (wr && i_bus.address == FCP_OFF_CMD && state == FCP_IDLE) |=> sector == $past(sector_start);
    endproperty
    a_start: assert property (p_start) else $error("first sector wrong");

endmodule : fcp_top

// *** design/fcp_pkg.sv ***
package fcp_pkg;

    // ------------------------------------------------------------------
    // Register map (word addresses, one per register)
    // ------------------------------------------------------------------
    localparam logic [3:0] FCP_OFF_MODE     = 4'h0; // Mode and control flags.
    localparam logic [3:0] FCP_OFF_SECTOR   = 4'h1; // Sector, count, size.
    localparam logic [3:0] FCP_OFF_SEEK     = 4'h2; // Seek offset and step interval.
    localparam logic [3:0] FCP_OFF_PERP     = 4'h3; // Perpendicular mode bits.
    localparam logic [3:0] FCP_OFF_CMD      = 4'h4; // Command launch.
    localparam logic [3:0] FCP_OFF_STATUS   = 4'h5; // Live status.
    localparam logic [3:0] FCP_OFF_RESULT   = 4'h6; // Four result bytes.
    localparam logic [3:0] FCP_OFF_DATA     = 4'h7; // Programmed data port.

    // ------------------------------------------------------------------
    // Mode register bit positions
    // ------------------------------------------------------------------
    localparam int FCP_B_NON_DMA   = 0;
    localparam int FCP_B_BYPASS    = 1;
    localparam int FCP_B_POLL_DIS  = 2;
    localparam int FCP_B_MULTI_TRK = 3;
    localparam int FCP_B_DDENS     = 4;
    localparam int FCP_B_VCOUNT    = 5;
    localparam int FCP_B_PREERASE  = 6;
    localparam int FCP_B_PERMIT    = 7;
    localparam int FCP_B_RATE      = 8;  // Two bits of data rate code.
    localparam int FCP_B_PRECOMP   = 16; // Eight bits of precomp start track.

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [31:0] FCP_RST_MODE    = 32'h0000_0010;
    localparam logic [7:0]  FCP_RST_SECTOR  = 8'h01;
    localparam logic [7:0]  FCP_RST_SPT     = 8'h09;
    localparam logic [2:0]  FCP_RST_SIZE    = 3'h2;
    localparam logic [3:0]  FCP_RST_STEP    = 4'h0;
    localparam int          FCP_CLK_MHZ     = 250;
    localparam real         FCP_STEP_UNIT_US = 500.0; // 0.5 ms at 1 Mbit.
    localparam int          FCP_STEP_UNIT_CYC = int'(FCP_STEP_UNIT_US * FCP_CLK_MHZ);
    localparam int          FCP_POLL_US     = 1000;
    localparam int          FCP_POLL_CYC    = FCP_POLL_US * FCP_CLK_MHZ;
    localparam int          FCP_BYTE_CYC    = 16; // Cycles per simulated media byte.
    localparam logic [3:0]  FCP_PREERASE_CYC = 4'h8;

    // Commands.
    typedef enum logic [2:0] {
        FCP_CMD_READ     = 3'h0,
        FCP_CMD_READ_DEL = 3'h1,
        FCP_CMD_WRITE    = 3'h2,
        FCP_CMD_FORMAT   = 3'h3,
        FCP_CMD_VERIFY   = 3'h4,
        FCP_CMD_RSEEK    = 3'h5,
        FCP_CMD_SENSE    = 3'h6
    } fcp_cmd_e;

    // Sequencer states, one-hot.
    typedef enum logic [4:0] {
        FCP_IDLE   = 5'b00001,
        FCP_SECTOR = 5'b00010,
        FCP_XFER   = 5'b00100,
        FCP_STEP   = 5'b01000,
        FCP_RESULT = 5'b10000
    } fcp_state_e;

    // Avalon-MM request.
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
    } fcp_bus_s;

    // Result bytes.
    typedef struct packed {
        logic [7:0] byte3;
        logic [7:0] byte2;
        logic [7:0] byte1;
        logic [7:0] byte0;
    } fcp_result_s;

endpackage : fcp_pkg

// *** verif/fcp_dma_model.sv ***
`timescale 1ns/1ps
// DMA controller stand-in; the wait before each answer sets a prompt or a slow partner.
module fcp_dma_model (
    input  wire logic       i_ref_clk, // Clock.
    input  wire logic       i_rst_n,   // Reset, active low.
    input  wire logic       i_req,     // Request from the block.
    input  wire logic [3:0] i_delay,   // Cycles before answering.
    output logic            o_ack      // Acknowledge to the block.
);
    logic [3:0] wait_cnt;

    // Answer only a standing request and withdraw the answer once it drops.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || !i_req) begin
            wait_cnt <= 4'h0;
            o_ack    <= 1'b0;
        end else if (wait_cnt < i_delay) begin
            wait_cnt <= wait_cnt + 4'h1;
        end else begin
            o_ack <= 1'b1;
        end
    end
endmodule : fcp_dma_model

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
    import fcp_pkg::*;
    logic        i_ref_clk, i_rst_n, ack, del_mark, req_q;
    fcp_bus_s    i_bus;
    logic [31:0] o_readdata, q;
    logic        o_waitrequest, o_dma_request, o_host_irq, o_mfm;
    logic        o_write_enable, o_head_sel, we_seen, head_seen;
    logic [3:0]  dly;
    int          num_errors, total_checks, dma_cnt, nb;

    fcp_top dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_bus(i_bus),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_dma_acknowledge(ack),
        .i_deleted_mark(del_mark), .o_dma_request(o_dma_request), .o_host_irq(o_host_irq),
        .o_step(), .o_write_enable(o_write_enable), .o_head_sel(o_head_sel),
        .o_poll_active(), .o_mfm(o_mfm));
    fcp_dma_model u_dma (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req(o_dma_request),
        .i_delay(dly), .o_ack(ack));

    // ------------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------------
    // The request is held until the edge that shows waitrequest low; only the watchdog
    // ends a wait that never gets its answer.
    task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_bus <= '{read: rd, write: !rd, address: a, writedata: d};
        do begin
            @(posedge i_ref_clk);
        end while (o_waitrequest !== 1'b0);
        q = o_readdata;
        i_bus <= '0;
    endtask : bus
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Launch a command, serve each per-byte request, stop once the sequencer idles.
    task automatic run(input fcp_cmd_e c);
        nb = 0;
        dma_cnt = 0;
        we_seen = 1'b0;
        head_seen = 1'b0;
        bus(1'b0, FCP_OFF_CMD, {29'h0, c});
        repeat (4) @(posedge i_ref_clk);
        for (int i = 0; i < 20000; i++) begin
            if (o_host_irq === 1'b1) begin
                bus(1'b1, FCP_OFF_DATA, 32'h0);
                nb++;
                @(posedge i_ref_clk);
            end else begin
                bus(1'b1, FCP_OFF_STATUS, 32'h0);
                if (q[0] === 1'b1) break;
            end
        end
    endtask : run

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk(o_mfm, 1'b1);
        chk(o_waitrequest, 1'b1);
        bus(1'b1, FCP_OFF_MODE, 32'h0);
        chk(q, FCP_RST_MODE);
        bus(1'b1, FCP_OFF_SECTOR, 32'h0);
        chk(q[15:0], {FCP_RST_SPT, FCP_RST_SECTOR});
        $display("test reset done");
    endtask : t_reset
    task automatic t_regs;
        bus(1'b0, FCP_OFF_PERP, 32'hf);
        bus(1'b1, FCP_OFF_PERP, 32'h0);
        chk(q[3:0], 4'h0);
        bus(1'b0, FCP_OFF_MODE, 32'h00ff_0090);
        bus(1'b0, FCP_OFF_PERP, 32'ha);
        bus(1'b1, FCP_OFF_PERP, 32'h0);
        chk(q[3:0], 4'ha);
        bus(1'b1, FCP_OFF_MODE, 32'h0);
        chk(q, 32'h00ff_0090);
        bus(1'b1, 4'h9, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, FCP_OFF_MODE, 32'h0);
        @(posedge i_ref_clk);
        chk(o_mfm, 1'b0);
        $display("test registers done");
    endtask : t_regs
    task automatic t_xfer;
        run(FCP_CMD_SENSE);
        bus(1'b1, FCP_OFF_RESULT, 32'h0);
        chk(q[15:8], 8'h00);
        bus(1'b0, FCP_OFF_MODE, 32'h11);
        bus(1'b0, FCP_OFF_SECTOR, 32'h0000_0109);
        run(FCP_CMD_READ);
        chk(nb, 128);
        chk(dma_cnt, 0);
        bus(1'b1, FCP_OFF_RESULT, 32'h0);
        chk(q[23:8], 16'h0a01);
        bus(1'b0, FCP_OFF_MODE, 32'h10);
        bus(1'b0, FCP_OFF_SECTOR, 32'h0001_0109);
        dly <= 4'h3;
        run(FCP_CMD_READ);
        chk(dma_cnt, 256);
        chk(nb, 0);
        $display("test transfers done");
    endtask : t_xfer
    task automatic t_skip;
        bus(1'b0, FCP_OFF_SECTOR, 32'h0000_0909);
        bus(1'b0, FCP_OFF_MODE, 32'h13);
        del_mark <= 1'b1;
        run(FCP_CMD_READ);
        chk(nb, 0);
        bus(1'b0, FCP_OFF_SECTOR, 32'h0000_0109);
        run(FCP_CMD_READ_DEL);
        chk(nb, 128);
        bus(1'b0, FCP_OFF_MODE, 32'h11);
        run(FCP_CMD_READ);
        chk(nb, 128);
        $display("test bypass done");
    endtask : t_skip
    // Write with multi-track and pre-erase: both heads, write enable seen.
    task automatic t_write;
        bus(1'b0, FCP_OFF_MODE, 32'h59);
        run(FCP_CMD_WRITE);
        chk(nb, 256);
        chk(head_seen, 1'b1);
        chk(we_seen, 1'b1);
        $display("test write done");
    endtask : t_write

    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    // Free-running clock at 250 MHz.
    initial begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    // Count rising DMA requests so each byte is seen once; note write enable and head one.
    always @(posedge i_ref_clk) begin
        if (o_dma_request === 1'b1 && req_q !== 1'b1) dma_cnt++;
        if (o_write_enable === 1'b1) we_seen = 1'b1;
        if (o_head_sel === 1'b1) head_seen = 1'b1;
        req_q <= o_dma_request;
    end
    // Watchdog sized well above the expected run of some 7.5k cycles.
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end
    // Main sequence.
    initial begin
        i_rst_n = 1'b0;
        i_bus = '0;
        del_mark = 1'b0;
        dly = 4'h0;
        repeat (10) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_xfer();
        t_skip();
        t_write();
        end_of_test();
    end
endmodule : tb
